// ---- logic/gaic_pkg.sv ----
// package: register map, reset values and carrier types of the gpio config block
package gaic_pkg;
  localparam logic [7:0]  ADDR_ALT_SET      = 8'h18;
  localparam logic [7:0]  ADDR_ALT_CLR      = 8'h1C;
  localparam logic [7:0]  ADDR_IEN_SET      = 8'h20;
  localparam logic [7:0]  ADDR_IEN_CLR      = 8'h24;
  localparam logic [7:0]  ADDR_TYPE_SET     = 8'h28;
  localparam logic [7:0]  ADDR_TYPE_CLR     = 8'h2C;
  localparam logic [7:0]  ADDR_POL_SET      = 8'h30;
  localparam logic [7:0]  ADDR_POL_CLR      = 8'h34;
  localparam logic [7:0]  ADDR_IRQ_STATUS   = 8'h38;
  localparam logic [7:0]  ADDR_IRQ_MASK     = 8'h3C;
  localparam logic [15:0] ALT_RESET_LOW     = 16'h0000;
  localparam logic [15:0] ALT_RESET_BANK2   = 16'hFFFF;
  localparam logic [15:0] CFG_RESET         = 16'h0000;
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

  typedef struct packed {
    logic [15:0] altSel;
    logic [15:0] irqEn;
    logic [15:0] irqEdge;
    logic [15:0] irqPol;
    logic [15:0] irqStatus;
    logic [15:0] irqMask;
    logic [15:0] pinSync1;
    logic [15:0] pinSync2;
    logic [15:0] pinPrev;
    logic [7:0]  awAddr;
    logic        awFull;
    logic [31:0] wData;
    logic        wFull;
    logic        bValid;
    logic [1:0]  bResp;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;
  } gaic_state_t;
endpackage

// ---- logic/gaic_gpio_cfg.sv ----
// gpio alternate-function and interrupt configuration with an axi4-lite slave
`timescale 1ns/1ns
module gaic_gpio_cfg
  import gaic_pkg::*;
#(
  parameter int BANK = 0
) (
  input  wire logic        clk,          // 25 MHz clock
  input  wire logic        rst,          // synchronous reset, active high
  input  wire logic [7:0]  s_axi_awaddr, // write address
  input  wire logic        s_axi_awvalid,// write address valid
  output logic             s_axi_awready,// write address ready
  input  wire logic [31:0] s_axi_wdata,  // write data
  input  wire logic [3:0]  s_axi_wstrb,  // write byte strobes
  input  wire logic        s_axi_wvalid, // write data valid
  output logic             s_axi_wready, // write data ready
  output logic [1:0]       s_axi_bresp,  // write response
  output logic             s_axi_bvalid, // write response valid
  input  wire logic        s_axi_bready, // write response ready
  input  wire logic [7:0]  s_axi_araddr, // read address
  input  wire logic        s_axi_arvalid,// read address valid
  output logic             s_axi_arready,// read address ready
  output logic [31:0]      s_axi_rdata,  // read data
  output logic [1:0]       s_axi_rresp,  // read response
  output logic             s_axi_rvalid, // read data valid
  input  wire logic        s_axi_rready, // read data ready
  input  wire logic [15:0] pinIn,        // external pin levels, asynchronous
  output logic [15:0]      altFunctionSelect, // per-pin alternate function select
  output logic [15:0]      pinIrq,       // per-pin interrupt request
  output logic             irq           // summary interrupt, level
);

  gaic_state_t st;
  gaic_state_t next_st;

  logic [15:0] levelHit;
  logic [15:0] edgeHit;
  logic [15:0] wrBits;
  logic        doWrite;
  logic        statusRead;
  logic [15:0] reqNow;
  logic [3:0]  s_axi_wstrb_q;

  // ----------------------------------------------------------------
  // request detection
  // ----------------------------------------------------------------
  always_comb begin
    levelHit = ~(st.pinSync2 ^ st.irqPol);
    edgeHit  = (st.pinSync2 & ~st.pinPrev & st.irqPol)
             | (~st.pinSync2 & st.pinPrev & ~st.irqPol);
    reqNow   = st.irqEn & ((st.irqEdge & edgeHit) | (~st.irqEdge & levelHit));
  end

  assign pinIrq            = reqNow;
  assign altFunctionSelect = st.altSel;
  assign irq               = |(st.irqStatus & st.irqMask);

  assign s_axi_awready = ~st.awFull & ~st.bValid;
  assign s_axi_wready  = ~st.wFull & ~st.bValid;
  assign s_axi_arready = ~st.rValid;
  assign s_axi_bvalid  = st.bValid;
  assign s_axi_bresp   = st.bResp;
  assign s_axi_rvalid  = st.rValid;
  assign s_axi_rdata   = st.rData;
  assign s_axi_rresp   = st.rResp;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.pinSync1 = pinIn;
    next_st.pinSync2 = st.pinSync1;
    next_st.pinPrev  = st.pinSync2;

    if (s_axi_awvalid && s_axi_awready) begin
      next_st.awAddr = s_axi_awaddr;
      next_st.awFull = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.wData = s_axi_wdata;
      next_st.wFull = 1'b1;
    end

    // upper half of the word is reserved; each low lane gates only its own byte of a set/clear
    doWrite = st.awFull && st.wFull;
    wrBits  = st.wData[15:0] & {{8{s_axi_wstrb_q[1]}}, {8{s_axi_wstrb_q[0]}}};
    statusRead = 1'b0;

    if (doWrite) begin
      next_st.awFull = 1'b0;
      next_st.wFull  = 1'b0;
      next_st.bValid = 1'b1;
      next_st.bResp  = RESP_OKAY;
      if (st.awAddr == ADDR_ALT_SET) begin
        next_st.altSel = st.altSel | wrBits;
      end else if (st.awAddr == ADDR_ALT_CLR) begin
        next_st.altSel = st.altSel & ~wrBits;
      end else if (st.awAddr == ADDR_IEN_SET) begin
        next_st.irqEn = st.irqEn | wrBits;
      end else if (st.awAddr == ADDR_IEN_CLR) begin
        next_st.irqEn = st.irqEn & ~wrBits;
      end else if (st.awAddr == ADDR_TYPE_SET) begin
        next_st.irqEdge = st.irqEdge | wrBits;
      end else if (st.awAddr == ADDR_TYPE_CLR) begin
        next_st.irqEdge = st.irqEdge & ~wrBits;
      end else if (st.awAddr == ADDR_POL_SET) begin
        next_st.irqPol = st.irqPol | wrBits;
      end else if (st.awAddr == ADDR_POL_CLR) begin
        next_st.irqPol = st.irqPol & ~wrBits;
      end else if (st.awAddr == ADDR_IRQ_MASK) begin
        next_st.irqMask = wrBits;
      end else if (st.awAddr != ADDR_IRQ_STATUS) begin
        next_st.bResp = RESP_SLVERR;
      end
    end
    if (st.bValid && s_axi_bready) begin
      next_st.bValid = 1'b0;
    end

    if (s_axi_arvalid && s_axi_arready) begin
      next_st.rValid = 1'b1;
      next_st.rResp  = RESP_OKAY;
      next_st.rData  = 32'h0000_0000;
      if (s_axi_araddr == ADDR_ALT_SET || s_axi_araddr == ADDR_ALT_CLR) begin
        next_st.rData[15:0] = st.altSel;
      end else if (s_axi_araddr == ADDR_IEN_SET || s_axi_araddr == ADDR_IEN_CLR) begin
        next_st.rData[15:0] = st.irqEn;
      end else if (s_axi_araddr == ADDR_TYPE_SET || s_axi_araddr == ADDR_TYPE_CLR) begin
        next_st.rData[15:0] = st.irqEdge;
      end else if (s_axi_araddr == ADDR_POL_SET || s_axi_araddr == ADDR_POL_CLR) begin
        next_st.rData[15:0] = st.irqPol;
      end else if (s_axi_araddr == ADDR_IRQ_STATUS) begin
        next_st.rData[15:0] = st.irqStatus;
        statusRead = 1'b1;
      end else if (s_axi_araddr == ADDR_IRQ_MASK) begin
        next_st.rData[15:0] = st.irqMask;
      end else begin
        next_st.rResp = RESP_SLVERR;
      end
    end
    if (st.rValid && s_axi_rready) begin
      next_st.rValid = 1'b0;
    end

    // read clears status; a request in the same cycle still sets its bit
    next_st.irqStatus = (statusRead ? 16'h0000 : st.irqStatus) | reqNow;
  end

  // strobes are sampled with the data beat
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_wstrb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wstrb_q <= s_axi_wstrb;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      st           <= '0;
      st.altSel    <= (BANK == 2) ? ALT_RESET_BANK2 : ALT_RESET_LOW;
      st.irqEn     <= CFG_RESET;
      st.irqEdge   <= CFG_RESET;
      st.irqPol    <= CFG_RESET;
    end else begin
      st <= next_st;
    end
  end

endmodule

// ---- tb/gaic_gpio_cfg_assertions.sv ----
// checker: port-level assertions of the gpio config block
`timescale 1ns/1ns
module gaic_gpio_cfg_assertions
  import gaic_pkg::*;
#(
  parameter int BANK = 0
) (
  input wire logic        clk, rst, irq,                       // clock, reset, request
  input wire logic        s_axi_awready, s_axi_wready,         // write readies
  input wire logic        s_axi_bvalid, s_axi_bready,          // write response
  input wire logic        s_axi_arready, s_axi_rvalid, s_axi_rready, // read handshake
  input wire logic [1:0]  s_axi_bresp, s_axi_rresp,            // response codes
  input wire logic [31:0] s_axi_rdata,                         // read data
  input wire logic [15:0] altFunctionSelect, pinIrq            // selections, requests
);
  localparam logic [15:0] ALT_EXP = (BANK == 2) ? ALT_RESET_BANK2 : ALT_RESET_LOW;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_rst_alt; $fell(rst) |-> altFunctionSelect == ALT_EXP; endproperty
  a_rst_alt: assert property (p_rst_alt) else $error("alt select reset value wrong");
  property p_rst_req; $fell(rst) |-> !irq && pinIrq == 16'h0000; endproperty
  a_rst_req: assert property (p_rst_req) else $error("request active after reset");
  // selection may only move with a completing write
  property p_alt_wr; !$past(rst) && !$stable(altFunctionSelect) |-> $rose(s_axi_bvalid); endproperty
  a_alt_wr: assert property (p_alt_wr) else $error("alt select moved without write");
  property p_upper; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits not zero");
  property p_err_zero; s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0; endproperty
  a_err_zero: assert property (p_err_zero) else $error("error read carries data");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data not held");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response not held");
  property p_one_wr; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_one_wr: assert property (p_one_wr) else $error("write taken while response pending");
  c_err: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  c_irq: cover property (irq);
  c_read: cover property (s_axi_rvalid && s_axi_rready && s_axi_rdata != 32'h0);
endmodule

// ---- tb/gaic_pin_model.sv ----
// model of the external pins driving the port inputs
`timescale 1ns/1ns
module gaic_pin_model (
  input  wire logic        clk,  // system clock
  input  wire logic [15:0] want, // levels asked for
  output logic      [15:0] pinIn // pin levels
);
  initial pinIn = 16'h0000;
  // pins move a little after the edge, never on it
  always @(posedge clk) pinIn <= #3 want;
endmodule

// ---- tb/gaic_gpio_cfg_bench.sv ----
// bench: register, reset and interrupt tests of the gpio config block
`timescale 1ns/1ns
module gaic_gpio_cfg_bench;
  import gaic_pkg::*;
  localparam int BANK = 2;
  logic        clk = 0, rst = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic        awr, wrd, bv, arr, rv, irq, ta, tw;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdata;
  logic [1:0]  bresp, rresp;
  logic [15:0] want = 16'h0, lvl = 16'h0, pinIn, alt, pinIrq, sh [4];
  logic [33:0] expQ [$];
  integer      seed = 32'h5867, bad_count = 0, num_checks = 0, cyc = 0;
  initial forever #20 clk = ~clk;
  gaic_pin_model i_pins (.clk(clk), .want(want), .pinIn(pinIn));
  gaic_gpio_cfg #(.BANK(BANK)) i_dut (.clk(clk), .rst(rst), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .pinIn(pinIn), .altFunctionSelect(alt), .pinIrq(pinIrq), .irq(irq));
  task automatic chk(input logic [33:0] got, exp, input string what);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs);
    @(posedge clk);
    expQ.push_back({rs, 32'h0});
    awa <= a;
    wd <= d;
    {awv, wv, br} <= 3'b111;
    do begin
      @(negedge clk);
      {ta, tw} = {awv & awr, wv & wrd};
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end while (awv | wv);
    do @(negedge clk); while (bv !== 1'b1);
    @(posedge clk);
    br <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge clk);
    expQ.push_back(e);
    ara <= a;
    {arv, rr} <= 2'b11;
    do @(negedge clk); while (arr !== 1'b1);
    @(posedge clk);
    arv <= 1'b0;
    do @(negedge clk); while (rv !== 1'b1);
    @(posedge clk);
    rr <= 1'b0;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      summarize();
    end
    if (bv && br) chk({bresp, 32'h0}, expQ.pop_front(), "write response");
    if (rv && rr) chk({rresp, rdata}, expQ.pop_front(), "read data");
  end
  initial begin
    sh = '{ALT_RESET_BANK2, CFG_RESET, CFG_RESET, CFG_RESET};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 10; k++) begin
      rd(8'h18 + 8'(4 * k), {RESP_OKAY, 16'h0, k < 8 ? sh[k / 2] : 16'h0});
    end
    $display("reset values done");
    for (int i = 0; i < 16; i++) begin
      logic [31:0] d;
      int          p;
      d = $random(seed);
      p = (i % 8) / 2;
      wr(8'h18 + 8'(4 * (i % 8)), d, RESP_OKAY);
      sh[p] = i[0] ? sh[p] & ~d[15:0] : sh[p] | d[15:0];
      lvl = lvl | (sh[1] & ~sh[2] & ~sh[3]);
      rd(8'h18 + 8'(8 * p), {RESP_OKAY, 16'h0, sh[p]});
      rd(8'h1C + 8'(8 * p), {RESP_OKAY, 16'h0, sh[p]});
      chk({18'h0, alt}, {18'h0, sh[0]}, "alt select");
    end
    $display("set and clear done");
    wr(8'h40, 32'hFFFF, RESP_SLVERR);
    rd(8'h40, {RESP_SLVERR, 32'h0});
    for (int k = 1; k < 8; k += 2) wr(8'h18 + 8'(4 * k), 32'hFFFF, RESP_OKAY);
    rd(ADDR_IRQ_STATUS, {RESP_OKAY, 16'h0, lvl});
    rd(ADDR_IRQ_STATUS, {RESP_OKAY, 32'h0});
    $display("refusal and clear done");
    wr(ADDR_TYPE_SET, 32'h1, RESP_OKAY);
    wr(ADDR_POL_SET, 32'h1, RESP_OKAY);
    wr(ADDR_IEN_SET, 32'h1, RESP_OKAY);
    wr(ADDR_IRQ_MASK, 32'h1, RESP_OKAY);
    want <= 16'h0001;
    for (int j = 0; j < 9 && irq !== 1'b1; j++) @(negedge clk);
    chk({33'h0, irq}, 34'h1, "irq raised");
    rd(ADDR_IRQ_STATUS, {RESP_OKAY, 32'h1});
    rd(ADDR_IRQ_STATUS, {RESP_OKAY, 32'h0});
    wr(ADDR_IRQ_MASK, 32'h0, RESP_OKAY);
    want <= 16'h0000;
    repeat (6) @(posedge clk);
    want <= 16'h0001;
    repeat (8) @(posedge clk);
    chk({33'h0, irq}, 34'h0, "irq masked");
    rd(ADDR_IRQ_STATUS, {RESP_OKAY, 32'h1});
    $display("interrupt done");
    summarize();
  end
endmodule
bind gaic_gpio_cfg gaic_gpio_cfg_assertions #(.BANK(BANK)) i_chk (.*);
